/* File: hw/gpt_axi_slave.sv */
// axi4-lite slave front end: one write and one read in flight.
// assumes the register file decodes and answers read data combinationally.
`timescale 1ns/100ps
module gpt_axi_slave (
  input  wire logic                 clk_sys,  // system clock
  input  wire logic                 rst_n,    // synchronous reset, active low
  input  wire logic [7:0]           awaddr,   // write address
  input  wire logic                 awvalid,  // write address valid
  output logic                      awready,  // write address ready
  input  wire logic [31:0]          wdata,    // write data
  input  wire logic [3:0]           wstrb,    // write strobes
  input  wire logic                 wvalid,   // write data valid
  output logic                      wready,   // write data ready
  output logic [1:0]                bresp,    // write response
  output logic                      bvalid,   // write response valid
  input  wire logic                 bready,   // write response ready
  input  wire logic [7:0]           araddr,   // read address
  input  wire logic                 arvalid,  // read address valid
  output logic                      arready,  // read address ready
  output logic [31:0]               rdata,    // read data
  output logic [1:0]                rresp,    // read response
  output logic                      rvalid,   // read data valid
  input  wire logic                 rready,   // read data ready
  output gpt_pkg::gpt_wreq_type     wr_req,   // captured write
  output logic                      wr_fire,  // apply write this cycle
  input  wire logic                 wr_hit,   // write address mapped
  output logic                      rd_take,  // read taken this cycle
  input  wire logic [31:0]          rd_data,  // read data for araddr
  input  wire logic                 rd_hit    // read address mapped
);
  gpt_pkg::gpt_wreq_type req_q, req_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // address and data land in either order, write goes once both are held
  always_comb begin
    awready   = !aw_full_q;
    wready    = !w_full_q;
    arready   = !rvalid_q;
    wr_fire   = aw_full_q & w_full_q & !bvalid_q;
    rd_take   = arvalid & arready;
    req_d     = req_q;
    aw_full_d = aw_full_q & !wr_fire;
    w_full_d  = w_full_q & !wr_fire;
    bvalid_d  = bvalid_q & !bready;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q & !rready;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (awvalid && awready) begin
      req_d.addr = awaddr;
      aw_full_d  = 1'b1;
    end
    if (wvalid && wready) begin
      req_d.data = wdata;
      req_d.strb = wstrb;
      w_full_d   = 1'b1;
    end
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d  = wr_hit ? gpt_pkg::RESP_OKAY : gpt_pkg::RESP_SLVERR;
    end
    if (rd_take) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_data;
      rresp_d  = rd_hit ? gpt_pkg::RESP_OKAY : gpt_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req_q     <= '0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= gpt_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= gpt_pkg::RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else begin
      req_q     <= req_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  assign wr_req = req_q;
  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp  = rresp_q;
  assign rdata  = rdata_q;
endmodule

/* File: hw/gpt_ctrl_irq.sv */
// first timer control bits and the timer interrupt mask, status and line.
// assumes the counter datapath on clk_sys supplies one-cycle event pulses
// and the raw pwm and trigger levels; only the capture pin is asynchronous.
`timescale 1ns/100ps
module gpt_ctrl_irq (
  input  wire logic        clk_sys,            // system clock, 250 MHz
  input  wire logic        rst_n,              // synchronous reset, active low
  input  wire logic [7:0]  awaddr,             // axi write address
  input  wire logic        awvalid,            // axi write address valid
  output logic             awready,            // axi write address ready
  input  wire logic [31:0] wdata,              // axi write data
  input  wire logic [3:0]  wstrb,              // axi write strobes
  input  wire logic        wvalid,             // axi write data valid
  output logic             wready,             // axi write data ready
  output logic [1:0]       bresp,              // axi write response
  output logic             bvalid,             // axi write response valid
  input  wire logic        bready,             // axi write response ready
  input  wire logic [7:0]  araddr,             // axi read address
  input  wire logic        arvalid,            // axi read address valid
  output logic             arready,            // axi read address ready
  output logic [31:0]      rdata,              // axi read data
  output logic [1:0]       rresp,              // axi read response
  output logic             rvalid,             // axi read data valid
  input  wire logic        rready,             // axi read data ready
  input  wire logic        capture_pin,        // first timer capture pin
  input  wire logic        first_timeout_in,   // first timer time-out pulse
  input  wire logic        first_match_in,     // first capture match pulse
  input  wire logic        clock_tick_in,      // real-time-clock event pulse
  input  wire logic        second_timeout_in,  // second timer time-out pulse
  input  wire logic        second_match_in,    // second capture match pulse
  input  wire logic        second_event_in,    // second capture event pulse
  input  wire logic        first_pwm_in,       // first timer raw pwm level
  input  wire logic        first_trigger_in,   // first timer raw trigger
  input  wire logic        debug_halt,         // debugger halt request
  output logic             first_timer_run,    // first timer enabled
  output logic             first_timer_stall,  // first timer held by debug
  output logic             clock_count_run,    // rtc counting enabled
  output logic             first_pwm_out,      // pwm after level control
  output logic             first_trigger_out,  // gated output trigger
  output logic             irq                 // timer interrupt, active high
);
  gpt_pkg::gpt_wreq_type wr_req;
  gpt_pkg::gpt_ctrl_type ctrl_q, ctrl_d;
  gpt_pkg::gpt_src_type  src;
  logic [31:0] mask_q, mask_d, raw_q, raw_d;
  logic [31:0] src_word, clr_word, set_clr;
  logic [31:0] rd_data;
  logic [31:0] ctrl_word;  // control word after a strobed merge
  logic        wr_fire, wr_hit, rd_take, rd_hit;
  logic        first_event;
  logic        pwm_q, pwm_d, trig_q, trig_d, stall_q, stall_d, irq_q, irq_d;

  // byte lanes selected by the write strobes
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // strobed merge of new data into a register, limited to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb,
                                        input logic [31:0] rw_bits);
    logic [31:0] sel;
    sel   = lane_mask(strb) & rw_bits;
    merge = (old_v & ~sel) | (new_v & sel);
  endfunction

  // true for the four word addresses this block answers
  function automatic logic mapped(input logic [7:0] addr);
    logic [7:0] word;
    word   = {addr[7:2], 2'h0};
    mapped = (word == gpt_pkg::CTRL_OFFSET) || (word == gpt_pkg::MASK_OFFSET) ||
             (word == gpt_pkg::RAW_OFFSET)  || (word == gpt_pkg::MIS_OFFSET);
  endfunction

  // place the seven source pulses at their status bit positions
  function automatic logic [31:0] place(input gpt_pkg::gpt_src_type s);
    logic [31:0] w;
    w = 32'h00000000;
    w[gpt_pkg::FIRST_TIMEOUT_BIT]  = s.first_timeout;
    w[gpt_pkg::FIRST_MATCH_BIT]    = s.first_capture_match;
    w[gpt_pkg::FIRST_EVENT_BIT]    = s.first_capture_event;
    w[gpt_pkg::CLOCK_EVENT_BIT]    = s.clock_event;
    w[gpt_pkg::SECOND_TIMEOUT_BIT] = s.second_timeout;
    w[gpt_pkg::SECOND_MATCH_BIT]   = s.second_capture_match;
    w[gpt_pkg::SECOND_EVENT_BIT]   = s.second_capture_event;
    place = w;
  endfunction

  gpt_axi_slave u_bus (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_req  (wr_req),
    .wr_fire (wr_fire),
    .wr_hit  (wr_hit),
    .rd_take (rd_take),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  // capture logic is armed only while the timer is enabled
  gpt_edge_detect u_edge (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .pin_in    (capture_pin),
    .arm       (ctrl_q.first_timer_enable),
    .edge_sel  (ctrl_q.first_capture_edge_select),
    .event_out (first_event)
  );

  // event sources; the rtc tick counts only while rtc counting is on
  always_comb begin
    src.first_timeout        = first_timeout_in;
    src.first_capture_match  = first_match_in;
    src.first_capture_event  = first_event;
    src.clock_event          = clock_tick_in & ctrl_q.clock_count_enable;
    src.second_timeout       = second_timeout_in;
    src.second_capture_match = second_match_in;
    src.second_capture_event = second_event_in;
  end

  // read mux, reserved bits read as zero
  always_comb begin
    rd_hit = mapped(araddr);
    wr_hit = mapped(wr_req.addr);
    case ({araddr[7:2], 2'h0})
      gpt_pkg::CTRL_OFFSET: rd_data = {25'h0000000, ctrl_q};
      gpt_pkg::MASK_OFFSET: rd_data = mask_q;
      gpt_pkg::RAW_OFFSET:  rd_data = raw_q;
      gpt_pkg::MIS_OFFSET:  rd_data = raw_q & mask_q;
      default:              rd_data = 32'h00000000;
    endcase
  end

  // register file next state; a raw flag set in the cycle of its clear stays set
  always_comb begin
    src_word  = place(src);
    clr_word  = 32'h00000000;
    // merged word kept whole, only the low seven bits are stored
    ctrl_word = merge({25'h0000000, ctrl_q}, wr_req.data, wr_req.strb, 32'h0000007F);
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    if (wr_fire) begin
      case ({wr_req.addr[7:2], 2'h0})
        gpt_pkg::CTRL_OFFSET:
          ctrl_d = ctrl_word[6:0];
        gpt_pkg::MASK_OFFSET:
          mask_d = merge(mask_q, wr_req.data, wr_req.strb,
                         gpt_pkg::IRQ_BITS);
        gpt_pkg::RAW_OFFSET:
          clr_word = wr_req.data & lane_mask(wr_req.strb) & gpt_pkg::IRQ_BITS;
        default: ;
      endcase
    end
    set_clr = src_word & clr_word;
    raw_d   = (raw_q & ~clr_word) | src_word;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= gpt_pkg::CTRL_RESET;
      mask_q <= gpt_pkg::MASK_RESET;
      raw_q  <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      raw_q  <= raw_d;
    end
  end

  // output stage: pwm level, trigger gate, stall permit, interrupt line
  always_comb begin
    pwm_d   = first_pwm_in ^ ctrl_q.first_pwm_invert;
    trig_d  = first_trigger_in & ctrl_q.first_trigger_out_enable;
    stall_d = debug_halt & ctrl_q.first_stall_enable;
    irq_d   = |(raw_q & mask_q);
  end

  // registered so every data output is glitch free, at one cycle of delay
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwm_q   <= 1'b0;
      trig_q  <= 1'b0;
      stall_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      pwm_q   <= pwm_d;
      trig_q  <= trig_d;
      stall_q <= stall_d;
      irq_q   <= irq_d;
    end
  end

  assign first_timer_run   = ctrl_q.first_timer_enable;
  assign clock_count_run   = ctrl_q.clock_count_enable;
  assign first_timer_stall = stall_q;
  assign first_pwm_out     = pwm_q;
  assign first_trigger_out = trig_q;
  assign irq               = irq_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_timer_off2;
    !ctrl_q.first_timer_enable [*2];
  endsequence

  sequence s_full_mask_write;
    wr_fire && {wr_req.addr[7:2], 2'h0} == gpt_pkg::MASK_OFFSET &&
      wr_req.strb == 4'hF;
  endsequence

  a_pwm_level: assert property (
    ##1 first_pwm_out == ($past(first_pwm_in) ^ $past(ctrl_q.first_pwm_invert)))
    else $error("pwm output does not follow the invert bit");

  a_trigger_gate: assert property (
    !ctrl_q.first_trigger_out_enable |=> !first_trigger_out)
    else $error("trigger escaped while disabled");

  a_rtc_gate: assert property (
    (clock_tick_in && !ctrl_q.clock_count_enable &&
     !raw_q[gpt_pkg::CLOCK_EVENT_BIT]) |=> !raw_q[gpt_pkg::CLOCK_EVENT_BIT])
    else $error("rtc event flagged with counting off");

  a_stall_gate: assert property (
    (debug_halt && ctrl_q.first_stall_enable) |=> first_timer_stall)
    else $error("stall not raised while permitted");

  a_capture_armed: assert property (
    s_timer_off2 |-> !first_event)
    else $error("capture event while the timer is disabled");

  a_mask_write: assert property (
    s_full_mask_write |=> mask_q == ($past(wr_req.data) & gpt_pkg::IRQ_BITS))
    else $error("mask register did not take a full write");

  a_mask_reserved: assert property (
    (mask_q & ~gpt_pkg::IRQ_BITS) == 32'h00000000)
    else $error("reserved mask bit set");

  a_mask_reset: assert property (
    $rose(rst_n) |-> mask_q == gpt_pkg::MASK_RESET && !irq)
    else $error("mask not cleared by reset");

  a_raw_unmasked: assert property (
    (src_word != 32'h00000000) |=> (raw_q & $past(src_word)) == $past(src_word))
    else $error("raw flag missed an event");

  a_set_wins: assert property (
    (set_clr != 32'h00000000) |=> (raw_q & $past(set_clr)) != 32'h00000000)
    else $error("clear beat a simultaneous event");

  a_irq_line: assert property (
    ##1 irq == (($past(raw_q) & $past(mask_q)) != 32'h00000000))
    else $error("interrupt line not the or of masked flags");

  a_irq_second: assert property (
    (raw_q[gpt_pkg::SECOND_EVENT_BIT] && mask_q[gpt_pkg::SECOND_EVENT_BIT]) |=> irq)
    else $error("second capture event not reaching the line");

  a_irq_clock: assert property (
    (raw_q == 32'h00000008 && !mask_q[gpt_pkg::CLOCK_EVENT_BIT]) |=> !irq)
    else $error("masked rtc event reached the line");

  a_irq_first: assert property (
    (raw_q[gpt_pkg::FIRST_MATCH_BIT] && mask_q[gpt_pkg::FIRST_MATCH_BIT]) |=> irq)
    else $error("first capture match not reaching the line");
endmodule

/* File: hw/gpt_edge_detect.sv */
// capture pin synchroniser and edge selector for the first timer.
// assumes the pin is asynchronous to clk_sys; event is a one-cycle pulse.
`timescale 1ns/100ps
module gpt_edge_detect (
  input  wire logic       clk_sys,   // system clock
  input  wire logic       rst_n,     // synchronous reset, active low
  input  wire logic       pin_in,    // raw capture pin
  input  wire logic       arm,       // capture logic armed
  input  wire logic [1:0] edge_sel,  // edge select code
  output logic            event_out  // registered edge pulse
);
  logic sync1_q, sync2_q, prev_q, event_q;
  logic sync1_d, sync2_d, prev_d, event_d;
  logic rise, fall;

  // edges seen only past the second stage
  always_comb begin
    sync1_d = pin_in;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    rise    = sync2_q & ~prev_q;
    fall    = ~sync2_q & prev_q;
    case (edge_sel)
      gpt_pkg::EDGE_RISE: event_d = arm & rise;
      gpt_pkg::EDGE_FALL: event_d = arm & fall;
      gpt_pkg::EDGE_BOTH: event_d = arm & (rise | fall);
      default:            event_d = 1'b0;  // reserved code captures nothing
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      event_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
      event_q <= event_d;
    end
  end

  assign event_out = event_q;

  a_edge_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (arm && edge_sel == gpt_pkg::EDGE_FALL && sync2_q && !prev_q) |=> !event_out)
    else $error("falling select fired on a rising edge");

  a_edge_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (edge_sel == gpt_pkg::EDGE_RESERVED) |=> !event_out)
    else $error("reserved edge code produced an event");
endmodule

/* File: hw/gpt_pkg.sv */
// How it works
// - control bit 6 set inverts the first timer's pwm output, clear passes it, reset 0.
// - control bit 5 set lets the first timer's output trigger out, clear blocks it, reset 0.
// - control bit 4 set enables real-time-clock counting, clear stops it, reset 0.
// - control bits 3:2 pick the capture edge: 00 rising, 01 falling, 11 both, 10 reserved.
// - control bit 1 set allows the first timer to stall, clear forbids it, reset 0.
// - control bit 0 set starts the first timer (counting or capture armed), clear stops it.
// - the mask register at 0x018 enables a source with a written 1 and disables it with a 0.
// - mask bit 3 gates the real-time-clock event interrupt.
// - mask bit 2 gates first capture event and mask bit 1 first capture match.
// - mask bit 0 gates first time-out, and bits 31:11 and 7:4 are read-only zero.
// - every mask bit resets to 0 so all timer interrupts start disabled.
// - raw flags are set by their events whatever the mask, the output only for enabled ones.
//
// package of the timer control and interrupt block: offsets, fields, carriers.
// assumes a 32-bit axi4-lite slave with an 8-bit byte address.
package gpt_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h0C;
  localparam logic [7:0] MASK_OFFSET = 8'h18;
  localparam logic [7:0] RAW_OFFSET  = 8'h1C;
  localparam logic [7:0] MIS_OFFSET  = 8'h20;

  // interrupt source bit positions, shared by mask, raw and masked status
  localparam int unsigned FIRST_TIMEOUT_BIT   = 0;
  localparam int unsigned FIRST_MATCH_BIT     = 1;
  localparam int unsigned FIRST_EVENT_BIT     = 2;
  localparam int unsigned CLOCK_EVENT_BIT     = 3;
  localparam int unsigned SECOND_TIMEOUT_BIT  = 8;
  localparam int unsigned SECOND_MATCH_BIT    = 9;
  localparam int unsigned SECOND_EVENT_BIT    = 10;

  // writable bits and reset values
  localparam logic [31:0] IRQ_BITS   = 32'h0000070F;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [6:0]  CTRL_RESET = 7'h00;

  // capture edge codes
  localparam logic [1:0] EDGE_RISE     = 2'h0;
  localparam logic [1:0] EDGE_FALL     = 2'h1;
  localparam logic [1:0] EDGE_RESERVED = 2'h2;
  localparam logic [1:0] EDGE_BOTH     = 2'h3;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register, bit 6 down to bit 0
  typedef struct packed {
    logic       first_pwm_invert;
    logic       first_trigger_out_enable;
    logic       clock_count_enable;
    logic [1:0] first_capture_edge_select;
    logic       first_stall_enable;
    logic       first_timer_enable;
  } gpt_ctrl_type;

  // one captured write: address, data, byte strobes
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } gpt_wreq_type;

  // the seven interrupt source pulses
  typedef struct packed {
    logic second_capture_event;
    logic second_capture_match;
    logic second_timeout;
    logic clock_event;
    logic first_capture_event;
    logic first_capture_match;
    logic first_timeout;
  } gpt_src_type;

endpackage

/* File: testbench/tb_top.sv */
// bench for the timer control and interrupt mask block over axi4-lite.
// assumes one clk_sys domain; inputs change by nba just after posedge.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, capture_pin, first_pwm_in, first_trigger_in, debug_halt;
  logic        first_timer_run, first_timer_stall, clock_count_run, first_pwm_out;
  logic        first_trigger_out, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp_v;
  logic [5:0]  ev;          // event pulses, first timeout up to second event
  int          n_fail, samples_checked;
  int          pos[6] = '{0, 1, 3, 8, 9, 10};
  gpt_ctrl_irq gpt_ctrl_irq_inst (.clk_sys, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .capture_pin, .first_timeout_in(ev[0]), .first_match_in(ev[1]),
    .clock_tick_in(ev[2]), .second_timeout_in(ev[3]), .second_match_in(ev[4]),
    .second_event_in(ev[5]), .first_pwm_in, .first_trigger_in, .debug_halt, .first_timer_run,
    .first_timer_stall, .clock_count_run, .first_pwm_out, .first_trigger_out, .irq);
  // free running clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // handshakes sampled at negedge so the comb readys are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    // one idle edge so bready is never lowered and raised in one step
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int i = 0; i < 50 && !hb; i++) begin
      @(negedge clk_sys);
      ha = awvalid & awready; hw = wvalid & wready; hb = bvalid;
      if (hb) resp_v = bresp;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    if (!hb) begin n_fail++; stop_test(); end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    hr = 1'b0;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int i = 0; i < 50 && !hr; i++) begin
      @(negedge clk_sys);
      ha = arvalid & arready; hr = rvalid;
      if (hr) begin rd_v = rdata; resp_v = rresp; end
      @(posedge clk_sys);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    if (!hr) begin n_fail++; stop_test(); end
  endtask
  // let registered outputs land, then look at negedge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic t_reset();
    rd(gpt_pkg::MASK_OFFSET); `CHK(rd_v, gpt_pkg::MASK_RESET)
    rd(gpt_pkg::CTRL_OFFSET); `CHK(rd_v, 32'h00000000)
    `CHK(irq, 1'b0)
  endtask
  task automatic t_mask();
    wr(gpt_pkg::MASK_OFFSET, 32'hFFFFFFFF); rd(gpt_pkg::MASK_OFFSET);
    `CHK(rd_v, gpt_pkg::IRQ_BITS)
    `CHK(resp_v, gpt_pkg::RESP_OKAY)
    wr(gpt_pkg::MASK_OFFSET, 32'h00000000); rd(gpt_pkg::MASK_OFFSET);
    `CHK(rd_v, 32'h00000000)
    rd(8'h40); `CHK(resp_v, gpt_pkg::RESP_SLVERR)
    wr(8'h40, 32'h00000001);
    `CHK(resp_v, gpt_pkg::RESP_SLVERR)
  endtask
  // control bits 6:4 and 1:0 set (edge select left 00), then all cleared, against raw levels of 1
  task automatic t_ctrl();
    first_pwm_in <= 1'b1; first_trigger_in <= 1'b1; debug_halt <= 1'b1;
    wr(gpt_pkg::CTRL_OFFSET, 32'h00000073); settle(2);
    `CHK(first_pwm_out, 1'b0)
    `CHK(first_trigger_out, 1'b1)
    `CHK(clock_count_run, 1'b1)
    `CHK(first_timer_stall, 1'b1)
    `CHK(first_timer_run, 1'b1)
    wr(gpt_pkg::CTRL_OFFSET, 32'h00000000); settle(2);
    `CHK({first_pwm_out, first_trigger_out, clock_count_run}, 3'h4)
    `CHK({first_timer_stall, first_timer_run}, 2'h0)
  endtask
  // each source but the first capture event: raw set while masked out, irq only once unmasked
  task automatic t_irq();
    // rtc tick with counting off must leave no flag
    @(posedge clk_sys);
    ev[2] <= 1'b1;
    @(posedge clk_sys);
    ev[2] <= 1'b0;
    settle(2);
    rd(gpt_pkg::RAW_OFFSET); `CHK(rd_v, 32'h00000000)
    wr(gpt_pkg::CTRL_OFFSET, 32'h00000010);
    for (int i = 0; i < 6; i++) begin
      wr(gpt_pkg::MASK_OFFSET, 32'h00000000);
      ev[i] <= 1'b1; @(posedge clk_sys); ev[i] <= 1'b0; settle(3);
      `CHK(irq, 1'b0)
      rd(gpt_pkg::RAW_OFFSET); `CHK(rd_v, 32'h1 << pos[i])
      wr(gpt_pkg::MASK_OFFSET, 32'h1 << pos[i]); settle(2);
      `CHK(irq, 1'b1)
      wr(gpt_pkg::RAW_OFFSET, 32'h1 << pos[i]); settle(2);
      `CHK(irq, 1'b0)
    end
  endtask
  // one capture pin step under a control word, raw event bit expected
  task automatic cap(input logic [31:0] c, input logic p, input logic [31:0] e);
    wr(gpt_pkg::CTRL_OFFSET, c); capture_pin <= p; settle(8);
    rd(gpt_pkg::RAW_OFFSET); `CHK(rd_v, e)
    wr(gpt_pkg::RAW_OFFSET, 32'h00000004);
  endtask
  task automatic t_cap();
    cap(32'h00000000, 1'b1, 32'h0);
    cap(32'h00000001, 1'b0, 32'h0);
    cap(32'h00000001, 1'b1, 32'h4);
    cap(32'h00000009, 1'b0, 32'h0);
    cap(32'h00000005, 1'b1, 32'h0);
    cap(32'h00000005, 1'b0, 32'h4);
    cap(32'h0000000D, 1'b1, 32'h4);
  endtask
  // reset for six cycles, then the scenarios in turn
  initial begin
    n_fail = 0; samples_checked = 0; rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'h0; ev = 6'h00; capture_pin = 1'b0; first_pwm_in = 1'b0;
    first_trigger_in = 1'b0; debug_halt = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset(); t_mask(); t_ctrl(); t_irq(); t_cap();
    stop_test();
  end
endmodule
